//--- design/bisw_info_status.sv
`timescale 1ns/10ps
module bisw_info_status
    import bisw_pkg::*;
#(
    parameter int WORD_W = 16
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    // configuration loader
    input wire logic LOAD_DONE_I,
    input wire logic LOAD_VALID_I,
    input wire logic [7:0] FLASH_ADDR_I,
    input wire logic [WORD_W-1:0] FLASH_WORD_I,
    input wire logic [WORD_W-1:0] CAPACITY_MAH_I,
    input wire logic [WORD_W-1:0] CAPACITY_MWH_I,
    input wire logic CAPACITY_UNIT_SELECT_I,
    input wire bisw_gauge_type GAUGE_I,
    // command from smbus transport
    input wire logic CMD_VALID_I,
    input wire bisw_cmd_type CMD_I,
    input wire logic BUSY_I,
    input wire logic [7:0] ALARM_I,
    output logic RESP_VALID_O,
    output logic [WORD_W-1:0] RESP_DATA_O,
    output logic [WORD_W-1:0] STATUS_O,
    // flash write-back
    output logic FLASH_WR_O,
    output logic [7:0] FLASH_WR_ADDR_O,
    output logic [WORD_W-1:0] FLASH_WR_DATA_O
);
    // the datapath is written for 16-bit words only
    if (WORD_W != 16) begin : g_width_check
        $error("bisw_info_status: WORD_W must be 16");
    end

    logic init_f, notchg_f, full_f, empty_f;
    logic next_init_f, next_notchg_f, next_full_f, next_empty_f;
    logic [7:0] full_clear_pct, next_full_clear_pct;
    logic [15:0] volt_w, spec_w, date_w, wear, step, acc;
    logic [15:0] next_volt_w, next_spec_w, next_date_w, next_wear, next_step, next_acc;
    logic fwr, next_fwr;
    logic [15:0] fwr_data, next_fwr_data;
    bisw_err_type err, next_err;
    logic rv, next_rv;
    logic [15:0] rdata, next_rdata;
    logic [16:0] acc_sum;

    // flash shadow, flags, wear count, command answers
    always_comb begin
        next_init_f = init_f;
        next_notchg_f = notchg_f;
        next_full_f = full_f;
        next_empty_f = empty_f;
        next_full_clear_pct = full_clear_pct;
        next_volt_w = volt_w;
        next_spec_w = spec_w;
        next_date_w = date_w;
        next_wear = wear;
        next_step = step;
        next_acc = acc;
        next_fwr = 1'b0;
        next_fwr_data = fwr_data;
        next_err = err;
        next_rv = 1'b0;
        next_rdata = rdata;
        acc_sum = {1'b0, acc} + {1'b0, GAUGE_I.charge_inc};
        // flash image loaded at full or partial reset
        if (LOAD_DONE_I) begin
            next_init_f = LOAD_VALID_I;
            case (FLASH_ADDR_I)
                FL_VOLTAGE: next_volt_w = FLASH_WORD_I;
                FL_SPEC: next_spec_w = FLASH_WORD_I;
                FL_DATE: next_date_w = FLASH_WORD_I;
                FL_WEAR: next_wear = FLASH_WORD_I;
                FL_WEAR_STEP: next_step = FLASH_WORD_I;
                FL_FULL_CLEAR: next_full_clear_pct = FLASH_WORD_I[7:0];
                default: next_init_f = LOAD_VALID_I;
            endcase
        end
        next_notchg_f = !GAUGE_I.charging;
        // set beats clear on both gauge flags
        if (GAUGE_I.charge_term || GAUGE_I.overcharge) begin
            next_full_f = 1'b1;
        end else if (GAUGE_I.rel_pct < full_clear_pct) begin
            next_full_f = 1'b0;
        end
        if ((GAUGE_I.below_end_voltage_threshold_2 && GAUGE_I.below_overload)
            || (GAUGE_I.rel_pct < GAUGE_I.low_pct)) begin
            next_empty_f = 1'b1;
        end else if (GAUGE_I.rel_pct >= EMPTY_CLEAR_PCT) begin
            next_empty_f = 1'b0;
        end
        // wear accumulation with saturation
        if (step != 16'h0000) begin
            if (acc_sum >= {1'b0, step}) begin
                next_acc = 16'(acc_sum - {1'b0, step});
                if (wear != WEAR_MAX) begin
                    next_wear = wear + 16'h0001;
                    next_fwr = 1'b1;
                    next_fwr_data = wear + 16'h0001;
                end
            end else begin
                next_acc = acc_sum[15:0];
            end
        end
        // command decode and error priority
        if (CMD_VALID_I) begin
            next_rv = 1'b1;
            next_rdata = 16'h0000;
            next_err = ERR_OK;
            if (BUSY_I) begin
                next_err = ERR_BUSY;
            end else if (CMD_I.other_fault) begin
                next_err = ERR_UNKNOWN;
            end else if (CMD_I.over_under) begin
                next_err = ERR_OVER_UNDER;
            end else if (CMD_I.defined_unimpl) begin
                next_err = ERR_UNSUPPORTED;
            end else if (CMD_I.code < CMD_STATUS || CMD_I.code > CMD_DATE) begin
                next_err = ERR_RESERVED;
            end else if (CMD_I.write && CMD_I.block && CMD_I.length != 8'h02) begin
                next_err = ERR_BLOCK_LENGTH;
            end else if (CMD_I.write) begin
                next_err = ERR_WRITE_REFUSED;
            end else begin
                case (CMD_I.code)
                    CMD_WEAR: next_rdata = wear;
                    CMD_CAPACITY: next_rdata = CAPACITY_UNIT_SELECT_I
                        ? CAPACITY_MWH_I : CAPACITY_MAH_I;
                    CMD_VOLTAGE: next_rdata = volt_w;
                    CMD_SPEC: next_rdata = spec_w;
                    CMD_DATE: next_rdata = date_w;
                    default: next_rdata = STATUS_O;
                endcase
            end
        end
    end

    // state registers
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            init_f <= 1'b0;
            notchg_f <= 1'b1;
            full_f <= 1'b0;
            empty_f <= 1'b0;
            full_clear_pct <= 8'h00;
            volt_w <= 16'h0000;
            spec_w <= 16'h0000;
            date_w <= 16'h0000;
            wear <= 16'h0000;
            step <= 16'h0000;
            acc <= 16'h0000;
            fwr <= 1'b0;
            fwr_data <= 16'h0000;
            err <= ERR_OK;
            rv <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            init_f <= next_init_f;
            notchg_f <= next_notchg_f;
            full_f <= next_full_f;
            empty_f <= next_empty_f;
            full_clear_pct <= next_full_clear_pct;
            volt_w <= next_volt_w;
            spec_w <= next_spec_w;
            date_w <= next_date_w;
            wear <= next_wear;
            step <= next_step;
            acc <= next_acc;
            fwr <= next_fwr;
            fwr_data <= next_fwr_data;
            err <= next_err;
            rv <= next_rv;
            rdata <= next_rdata;
        end
    end

    // outputs
    assign STATUS_O = {ALARM_I, init_f, notchg_f, full_f, empty_f, 1'b0, err};
    assign RESP_VALID_O = rv;
    assign RESP_DATA_O = rdata;
    assign FLASH_WR_O = fwr;
    assign FLASH_WR_ADDR_O = FL_WEAR;
    assign FLASH_WR_DATA_O = fwr_data;

    // helper terms for the command checks
    logic cmd_clean;
    logic cmd_in_range;
    assign cmd_clean = CMD_VALID_I && !BUSY_I && !CMD_I.other_fault && !CMD_I.over_under
        && !CMD_I.defined_unimpl; // no fault outranks the decode
    assign cmd_in_range = CMD_I.code >= CMD_STATUS && CMD_I.code <= CMD_DATE;

    // status flag checks
    AST_INIT: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        LOAD_DONE_I |=> STATUS_O[ST_INIT_BIT] == $past(LOAD_VALID_I))
        else $error("init flag");
    AST_NOTCHG: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        $past(NRST_I) |-> STATUS_O[ST_NOTCHG_BIT] == !$past(GAUGE_I.charging))
        else $error("not-charging flag wrong");
    AST_FULL_SET: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        GAUGE_I.charge_term |=> STATUS_O[ST_FULL_BIT])
        else $error("full not set");
    AST_FULL_OVER: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        GAUGE_I.overcharge |=> STATUS_O[ST_FULL_BIT])
        else $error("full not set on overcharge");
    AST_FULL_CLR: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        !GAUGE_I.charge_term && !GAUGE_I.overcharge && GAUGE_I.rel_pct < full_clear_pct
        |=> !STATUS_O[ST_FULL_BIT])
        else $error("full not cleared");
    AST_EMPTY_SET: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (GAUGE_I.below_end_voltage_threshold_2 && GAUGE_I.below_overload) || GAUGE_I.rel_pct < GAUGE_I.low_pct
        |=> STATUS_O[ST_EMPTY_BIT])
        else $error("empty not set");
    AST_EMPTY_CLR: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        GAUGE_I.rel_pct >= EMPTY_CLEAR_PCT && !GAUGE_I.below_end_voltage_threshold_2
        && GAUGE_I.rel_pct >= GAUGE_I.low_pct |=> !STATUS_O[ST_EMPTY_BIT])
        else $error("empty not cleared");
    AST_LAYOUT: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        STATUS_O[15:8] == ALARM_I && STATUS_O[3] == 1'b0)
        else $error("status layout");

    // error code checks
    AST_BUSY: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CMD_VALID_I && BUSY_I |=> STATUS_O[2:0] == ERR_BUSY && RESP_DATA_O == 16'h0000)
        else $error("busy lost");
    AST_UNKNOWN: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CMD_VALID_I && !BUSY_I && CMD_I.other_fault |=> STATUS_O[2:0] == ERR_UNKNOWN)
        else $error("unknown error lost");
    AST_OVER_UNDER: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CMD_VALID_I && !BUSY_I && !CMD_I.other_fault && CMD_I.over_under
        |=> STATUS_O[2:0] == ERR_OVER_UNDER) else $error("overflow error lost");
    AST_UNSUP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CMD_VALID_I && !BUSY_I && !CMD_I.other_fault && !CMD_I.over_under
        && CMD_I.defined_unimpl |=> STATUS_O[2:0] == ERR_UNSUPPORTED)
        else $error("unsupported error lost");
    AST_RESERVED: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        cmd_clean && !cmd_in_range |=> STATUS_O[2:0] == ERR_RESERVED)
        else $error("reserved error lost");
    AST_BLOCK_LEN: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        cmd_clean && cmd_in_range && CMD_I.write && CMD_I.block && CMD_I.length != 8'h02
        |=> STATUS_O[2:0] == ERR_BLOCK_LENGTH)
        else $error("block length error lost");
    AST_REFUSE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        cmd_clean && cmd_in_range && CMD_I.write
        && (!CMD_I.block || CMD_I.length == 8'h02) |=> err == ERR_WRITE_REFUSED)
        else $error("write not refused");
    AST_OK: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        cmd_clean && cmd_in_range && !CMD_I.write |=> STATUS_O[2:0] == ERR_OK)
        else $error("ok code not restored");

    // response and word checks
    AST_RESP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CMD_VALID_I |=> RESP_VALID_O ##1 (!RESP_VALID_O || $past(CMD_VALID_I)))
        else $error("response timing");
    AST_VOLT: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        cmd_clean && !CMD_I.write && CMD_I.code == CMD_VOLTAGE
        |=> RESP_DATA_O == $past(volt_w)) else $error("voltage word");
    AST_SPEC: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        cmd_clean && !CMD_I.write && CMD_I.code == CMD_SPEC
        |=> RESP_DATA_O == $past(spec_w)) else $error("spec word");
    AST_DATE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        cmd_clean && !CMD_I.write && CMD_I.code == CMD_DATE
        |=> RESP_DATA_O == $past(date_w)) else $error("date word");
    AST_WEAR_RD: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        cmd_clean && !CMD_I.write && CMD_I.code == CMD_WEAR
        |=> RESP_DATA_O == $past(wear)) else $error("wear word");
    AST_CAP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        cmd_clean && !CMD_I.write && CMD_I.code == CMD_CAPACITY
        |=> RESP_DATA_O == ($past(CAPACITY_UNIT_SELECT_I) ? $past(CAPACITY_MWH_I)
        : $past(CAPACITY_MAH_I))) else $error("capacity word");

    // wear counter checks
    AST_WEAR_STEP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        step != 16'h0000 && acc_sum >= {1'b0, step} && wear != WEAR_MAX
        |=> wear == $past(wear) + 16'h0001)
        else $error("wear did not advance");
    AST_WEAR_SAT: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        $past(wear) == WEAR_MAX && !($past(LOAD_DONE_I) && $past(FLASH_ADDR_I) == FL_WEAR)
        |-> wear == WEAR_MAX) else $error("wear wrapped");
    AST_WEAR_WB: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (wear != $past(wear) && !$past(LOAD_DONE_I)) |-> fwr && fwr_data == wear)
        else $error("wear not written back");

    // main scenarios
    COV_WEAR_INC: cover property (@(posedge CLK_I) disable iff (!NRST_I) fwr);
    COV_READ_DATE: cover property (@(posedge CLK_I) disable iff (!NRST_I)
        CMD_VALID_I && CMD_I.code == CMD_DATE);
    COV_RESERVED: cover property (@(posedge CLK_I) disable iff (!NRST_I) err == ERR_RESERVED);
    COV_FULL_SET: cover property (@(posedge CLK_I) disable iff (!NRST_I) $rose(full_f));
    COV_BUSY: cover property (@(posedge CLK_I) disable iff (!NRST_I) err == ERR_BUSY);
endmodule

//--- design/bisw_pkg.sv
package bisw_pkg;
    // smbus function codes served here
    localparam logic [7:0] CMD_STATUS = 8'h16;
    localparam logic [7:0] CMD_WEAR = 8'h17;
    localparam logic [7:0] CMD_CAPACITY = 8'h18;
    localparam logic [7:0] CMD_VOLTAGE = 8'h19;
    localparam logic [7:0] CMD_SPEC = 8'h1a;
    localparam logic [7:0] CMD_DATE = 8'h1b;
    // flash locations (high byte address of each word)
    localparam logic [7:0] FL_VOLTAGE = 8'h04;
    localparam logic [7:0] FL_SPEC = 8'h06;
    localparam logic [7:0] FL_DATE = 8'h08;
    localparam logic [7:0] FL_WEAR = 8'h0c;
    localparam logic [7:0] FL_WEAR_STEP = 8'h37;
    localparam logic [7:0] FL_FULL_CLEAR = 8'h47;
    // status word fields
    localparam int ST_INIT_BIT = 7;
    localparam int ST_NOTCHG_BIT = 6;
    localparam int ST_FULL_BIT = 5;
    localparam int ST_EMPTY_BIT = 4;
    localparam logic [7:0] EMPTY_CLEAR_PCT = 8'd20;
    localparam logic [15:0] WEAR_MAX = 16'hffff;
    // spec word and date field positions
    localparam int SPEC_MINOR_LSB = 0;
    localparam int SPEC_MAJOR_LSB = 4;
    localparam int SPEC_VOLTAGE_SCALE_EXP_LSB = 8;
    localparam int SPEC_ISCALE_LSB = 12;
    localparam int DATE_DAY_LSB = 0;
    localparam int DATE_MONTH_LSB = 5;
    localparam int DATE_YEAR_LSB = 9;
    localparam int DATE_YEAR_BIAS = 1980;

    typedef enum logic [2:0] {
        ERR_OK = 3'h0,
        ERR_BUSY = 3'h1,
        ERR_RESERVED = 3'h2,
        ERR_UNSUPPORTED = 3'h3,
        ERR_WRITE_REFUSED = 3'h4,
        ERR_OVER_UNDER = 3'h5,
        ERR_BLOCK_LENGTH = 3'h6,
        ERR_UNKNOWN = 3'h7
    } bisw_err_type;

    // one command presented by the smbus transport
    typedef struct packed {
        logic [7:0] code;
        logic write;
        logic block;
        logic [7:0] length;
        logic defined_unimpl;
        logic over_under;
        logic other_fault;
    } bisw_cmd_type;

    // gauge measurements and conditions
    typedef struct packed {
        logic [7:0] rel_pct;
        logic charging;
        logic charge_term;
        logic overcharge;
        logic below_end_voltage_threshold_2;
        logic below_overload;
        logic [7:0] low_pct;
        logic [15:0] charge_inc;
    } bisw_gauge_type;
endpackage

//--- verification/bisw_host_model.sv
`timescale 1ns/10ps
module bisw_host_model
    import bisw_pkg::*;
(
    input wire logic clk_i,
    input wire logic go_i,
    input wire bisw_cmd_type req_i,
    output logic cmd_valid_o,
    output bisw_cmd_type cmd_o,
    input wire logic resp_valid_i,
    input wire logic [15:0] resp_data_i,
    input wire logic [15:0] status_i,
    output logic done_o,
    output logic [15:0] data_o,
    output logic [2:0] err_o
);
    // host issues one request from req_i, read or write, captures the word and error code
    always @(posedge clk_i) begin
        cmd_valid_o <= go_i;
        cmd_o <= go_i ? req_i : ~req_i;
        done_o <= resp_valid_i;
        if (resp_valid_i) begin
            data_o <= resp_data_i;
            err_o <= status_i[2:0];
        end
    end
endmodule

//--- verification/tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, (got), (exp)); end end
module tb;
    import bisw_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic load_done = 1'b0;
    logic load_valid = 1'b1;
    logic [7:0] flash_addr = 8'h0;
    logic [15:0] flash_word = 16'h0;
    logic cap_sel = 1'b0;
    logic busy = 1'b0;
    logic go = 1'b0;
    bisw_cmd_type req = '0;
    bisw_gauge_type gauge;
    logic cmd_valid, resp_valid, flash_wr, h_done;
    bisw_cmd_type cmd;
    logic [15:0] resp_data, status, flash_wr_data, h_data;
    logic [7:0] flash_wr_addr;
    logic [2:0] h_err;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int wr_cnt = 0;
    logic [15:0] last_wr = 16'h0;
    localparam logic [15:0] DATE_W = 16'((2002 - 1980) * 512 + 2 * 32 + 15);

    bisw_info_status bisw_info_status_i (.CLK_I(clk), .NRST_I(nrst), .LOAD_DONE_I(load_done),
        .LOAD_VALID_I(load_valid), .FLASH_ADDR_I(flash_addr), .FLASH_WORD_I(flash_word),
        .CAPACITY_MAH_I(16'h1234), .CAPACITY_MWH_I(16'h5678), .CAPACITY_UNIT_SELECT_I(cap_sel),
        .GAUGE_I(gauge), .CMD_VALID_I(cmd_valid), .CMD_I(cmd), .BUSY_I(busy),
        .ALARM_I(8'ha5), .RESP_VALID_O(resp_valid), .RESP_DATA_O(resp_data),
        .STATUS_O(status), .FLASH_WR_O(flash_wr), .FLASH_WR_ADDR_O(flash_wr_addr),
        .FLASH_WR_DATA_O(flash_wr_data));
    bisw_host_model bisw_host_model_i (.clk_i(clk), .go_i(go), .req_i(req),
        .cmd_valid_o(cmd_valid), .cmd_o(cmd), .resp_valid_i(resp_valid),
        .resp_data_i(resp_data), .status_i(status), .done_o(h_done), .data_o(h_data),
        .err_o(h_err));

    // clock and cycle ceiling
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("[ERR] %0t run did not finish", $time);
            complete_run();
        end
    end
    // flash write-back watcher
    always @(posedge clk) begin
        if (flash_wr === 1'b1) begin
            wr_cnt++;
            last_wr <= flash_wr_data;
            `CHK(flash_wr_addr, FL_WEAR)
        end
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one host request, flt = {defined_unimpl, over_under, other_fault}
    task automatic ck(input logic [7:0] code, input logic wr, input logic blk,
        input logic [7:0] len, input logic [2:0] flt, input logic [15:0] ed, input logic [2:0] ee);
        int k;
        @(posedge clk);
        go <= 1'b1;
        req <= {code, wr, blk, len, flt};
        @(posedge clk);
        go <= 1'b0;
        for (k = 0; k < 8 && h_done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        `CHK(h_done, 1'b1)
        `CHK(h_data, ed)
        `CHK(h_err, ee)
        @(posedge clk);
    endtask
    task automatic fl(input logic [7:0] a, input logic [15:0] w);
        @(posedge clk);
        load_done <= 1'b1;
        flash_addr <= a;
        flash_word <= w;
        @(posedge clk);
        load_done <= 1'b0;
    endtask
    task automatic st(input logic [3:0] e);
        repeat (2) @(posedge clk);
        #1;
        `CHK(status[7:4], e)
        @(posedge clk);
    endtask

    // main sequence
    initial begin
        gauge = '0;
        gauge.rel_pct = 8'h32;
        gauge.low_pct = 8'h0a;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        fl(FL_VOLTAGE, 16'h2a30);
        fl(FL_SPEC, 16'h0031);
        fl(FL_DATE, DATE_W);
        fl(FL_WEAR, 16'h0005);
        fl(FL_WEAR_STEP, 16'h0064);
        fl(FL_FULL_CLEAR, 16'h0050);
        st(4'hc);
        `CHK(status[15:8], 8'ha5)
        ck(CMD_VOLTAGE, 0, 0, 8'h02, 3'h0, 16'h2a30, ERR_OK);
        ck(CMD_SPEC, 0, 0, 8'h02, 3'h0, 16'h0031, ERR_OK);
        ck(CMD_DATE, 0, 0, 8'h02, 3'h0, DATE_W, ERR_OK);
        ck(CMD_CAPACITY, 0, 0, 8'h02, 3'h0, 16'h1234, ERR_OK);
        cap_sel <= 1'b1;
        ck(CMD_CAPACITY, 0, 0, 8'h02, 3'h0, 16'h5678, ERR_OK);
        ck(CMD_WEAR, 0, 0, 8'h02, 3'h0, 16'h0005, ERR_OK);
        ck(CMD_STATUS, 0, 0, 8'h02, 3'h0, 16'ha5c0, ERR_OK);
        ck(8'h30, 0, 0, 8'h02, 3'h0, 16'h0, ERR_RESERVED);
        ck(CMD_VOLTAGE, 0, 0, 8'h02, 3'h4, 16'h0, ERR_UNSUPPORTED);
        ck(CMD_VOLTAGE, 1, 1, 8'h03, 3'h0, 16'h0, ERR_BLOCK_LENGTH);
        ck(CMD_VOLTAGE, 1, 0, 8'h02, 3'h0, 16'h0, ERR_WRITE_REFUSED);
        ck(CMD_WEAR, 1, 1, 8'h02, 3'h0, 16'h0, ERR_WRITE_REFUSED);
        ck(CMD_VOLTAGE, 0, 0, 8'h02, 3'h2, 16'h0, ERR_OVER_UNDER);
        ck(CMD_VOLTAGE, 0, 0, 8'h02, 3'h3, 16'h0, ERR_UNKNOWN);
        busy <= 1'b1;
        ck(CMD_VOLTAGE, 0, 0, 8'h02, 3'h0, 16'h0, ERR_BUSY);
        busy <= 1'b0;
        ck(CMD_VOLTAGE, 0, 0, 8'h02, 3'h0, 16'h2a30, ERR_OK);
        gauge.charging <= 1'b1;
        st(4'h8);
        gauge.rel_pct <= 8'h5a;
        gauge.charge_term <= 1'b1;
        @(posedge clk);
        gauge.charge_term <= 1'b0;
        st(4'ha);
        gauge.rel_pct <= 8'h4f;
        st(4'h8);
        gauge.rel_pct <= 8'h5a;
        gauge.overcharge <= 1'b1;
        @(posedge clk);
        gauge.overcharge <= 1'b0;
        st(4'ha);
        gauge.rel_pct <= 8'h13;
        gauge.below_end_voltage_threshold_2 <= 1'b1;
        gauge.below_overload <= 1'b1;
        @(posedge clk);
        gauge.below_end_voltage_threshold_2 <= 1'b0;
        st(4'h9);
        gauge.rel_pct <= 8'h14;
        st(4'h8);
        gauge.rel_pct <= 8'h09;
        st(4'h9);
        gauge.rel_pct <= 8'h14;
        st(4'h8);
        gauge.charge_inc <= 16'h0064;
        @(posedge clk);
        gauge.charge_inc <= 16'h0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(wr_cnt, 1)
        `CHK(last_wr, 16'h0006)
        ck(CMD_WEAR, 0, 0, 8'h02, 3'h0, 16'h0006, ERR_OK);
        fl(FL_WEAR, 16'hfffe);
        gauge.charge_inc <= 16'h0064;
        repeat (3) @(posedge clk);
        gauge.charge_inc <= 16'h0;
        ck(CMD_WEAR, 0, 0, 8'h02, 3'h0, 16'hffff, ERR_OK);
        `CHK(wr_cnt, 2)
        load_valid <= 1'b0;
        fl(FL_SPEC, 16'h0031);
        st(4'h0);
        // reset in mid-run: flags and words fall back to their idle values
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(status, 16'ha540)
        @(posedge clk);
        nrst <= 1'b1;
        ck(CMD_VOLTAGE, 0, 0, 8'h02, 3'h0, 16'h0000, ERR_OK);
        complete_run();
    end
endmodule
